// *** oau_pkg.sv ***
package oau_pkg;

  // Sizes of the assembler set and of the order fields
  localparam int NUM_ASM  = 4;
  localparam int CHAN_W   = 4;
  localparam int NUM_UNIT = 16;
  localparam int CMD_W    = 3;
  localparam int CNT_W    = 4;
  localparam int MADDR_W  = 15;
  localparam int OP_W     = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_ORDER     = 8'h00;
  localparam logic [7:0] OFS_MADDR     = 8'h04;
  localparam logic [7:0] OFS_ISSUE     = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_AVAIL     = 8'h10;
  localparam logic [7:0] OFS_VIEW_SEL  = 8'h14;
  localparam logic [7:0] OFS_VIEW_PAR  = 8'h18;
  localparam logic [7:0] OFS_VIEW_ADDR = 8'h1C;

  // Field positions in the order register
  localparam int OP_LSB    = 0;
  localparam int UNIT_LSB  = 5;
  localparam int PROC_LSB  = 9;
  localparam int SPACE_LSB = 13;
  localparam int CMD_LSB   = 17;

  // Reset values
  localparam logic [31:0] ORDER_RST = 32'h0000_0000;
  localparam logic [14:0] MADDR_RST = 15'h0000;

  // Last operation code of each order class
  localparam logic [4:0] OP_A_LAST   = 5'h0B;
  localparam logic [4:0] OP_B_LAST   = 5'h0F;
  localparam logic [4:0] OP_C_LAST   = 5'h15;
  localparam logic [4:0] OP_D_LAST   = 5'h19;
  localparam logic [4:0] OP_UBC_LAST = 5'h1C;

  // Continue deadline, a longest time, so rounded down
  localparam int CLK_NS         = 20;
  localparam int CONT_LIMIT_NS  = 15000;
  localparam int CONT_LIMIT_CYC = CONT_LIMIT_NS / CLK_NS;

  typedef enum logic [2:0] {
    OC_A   = 3'b000,
    OC_B   = 3'b001,
    OC_C   = 3'b010,
    OC_D   = 3'b011,
    OC_UBC = 3'b100,
    OC_BAD = 3'b101
  } oau_class_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EVAL = 2'b01,
    ST_CONT = 2'b10,
    ST_LOAD = 2'b11
  } oau_state_t;

endpackage

// *** oau_order_class.sv ***
`timescale 1ns/10ps
module oau_order_class (
  input  wire logic [4:0]         op_code,
  output oau_pkg::oau_class_t     order_class
);

  // Sort the operation code into its acceptance class
  always_comb begin
    if (op_code <= oau_pkg::OP_A_LAST) begin
      order_class = oau_pkg::OC_A;
    end else if (op_code <= oau_pkg::OP_B_LAST) begin
      order_class = oau_pkg::OC_B;
    end else if (op_code <= oau_pkg::OP_C_LAST) begin
      order_class = oau_pkg::OC_C;
    end else if (op_code <= oau_pkg::OP_D_LAST) begin
      order_class = oau_pkg::OC_D;
    end else if (op_code <= oau_pkg::OP_UBC_LAST) begin
      order_class = oau_pkg::OC_UBC;
    end else begin
      order_class = oau_pkg::OC_BAD;
    end
  end

endmodule

// *** oau_assembler.sv ***
`timescale 1ns/10ps
module oau_assembler (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        connect,
  input  wire logic                        release_req,
  input  wire logic                        load_all,
  input  wire logic                        load_chan,
  input  wire logic [oau_pkg::CHAN_W-1:0]  chan_in,
  input  wire logic [oau_pkg::CMD_W-1:0]   cmd_in,
  input  wire logic [oau_pkg::MADDR_W-1:0] maddr_in,
  input  wire logic [oau_pkg::CNT_W-1:0]   proc_in,
  input  wire logic [oau_pkg::CNT_W-1:0]   space_in,
  input  wire logic                        xfer_active,
  input  wire logic                        mem_access,
  input  wire logic                        block_ok,
  input  wire logic                        block_spaced,
  input  wire logic                        xfer_done,
  output logic                             busy_r,
  output logic                             run_r,
  output logic [oau_pkg::CHAN_W-1:0]       chan_r,
  output logic [oau_pkg::CMD_W-1:0]        cmd_r,
  output logic [oau_pkg::MADDR_W-1:0]      maddr_r,
  output logic [oau_pkg::CNT_W-1:0]        proc_r,
  output logic [oau_pkg::CNT_W-1:0]        space_r
);

  // Connection state; a new connection wins over a same-cycle release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else if (connect) begin
      busy_r <= 1'b1;
    end else if (release_req || xfer_done) begin
      busy_r <= 1'b0;
    end
  end

  // Running only while connected and moving data; an error stop keeps busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
    end else begin
      run_r <= busy_r && xfer_active && !release_req && !xfer_done;
    end
  end

  // Device channel survives completion; rewritten only for another device
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_r <= '0;
    end else if (load_chan && (chan_r != chan_in)) begin
      chan_r <= chan_in;
    end
  end

  // Command field selects the transfer direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= '0;
    end else if (load_all) begin
      cmd_r <= cmd_in;
    end
  end

  // Memory address loads the first location, steps per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_r <= oau_pkg::MADDR_RST;
    end else if (load_all) begin
      maddr_r <= maddr_in;
    end else if (mem_access) begin
      maddr_r <= maddr_r + 1'b1;
    end
  end

  // Block counters count down on good blocks and spaced blocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_r  <= '0;
      space_r <= '0;
    end else if (load_all) begin
      proc_r  <= proc_in;
      space_r <= space_in;
    end else begin
      if (block_ok && (proc_r != '0)) begin
        proc_r <= proc_r - 1'b1;
      end
      if (block_spaced && (space_r != '0)) begin
        space_r <= space_r - 1'b1;
      end
    end
  end

endmodule

// *** oau_accept.sv ***
`timescale 1ns/10ps
// Function
// - Channel register kept until other device assigned
// - Sort tape orders into five classes, A to D and controller
// - Busy when connected, running when also transferring
// - Class A and controller need nonbusy assembler
// - Class B accepted if any channel matches
// - Class C: matching assembler idle, unit available
// - Class D: valid, available, idle unit only
// - Prefer nonbusy matching assembler, else lowest nonbusy
// - Class A, D and controller continue only if device free and available
// - Continue within fifteen microseconds of issue
// - Controller order keeps only channel parameter
// - Class A loads all parameters after continue
// - Command register takes the command field
// - Memory address loads, increments per access
// - Process count decrements per good block
// - Spacing count decrements per spaced block
// - Channel register four bits, sixteen channels
// - Availability status two bits per assembler
// - Stop/release disconnect; error stop stays connected
module oau_accept #(
  parameter logic [15:0] VALID_UNITS = 16'hFFFF
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [oau_pkg::NUM_UNIT-1:0]  unit_busy_pin,
  input  wire logic [oau_pkg::NUM_UNIT-1:0]  unit_mech_ok_pin,
  input  wire logic [oau_pkg::NUM_ASM-1:0]   asm_xfer_active,
  input  wire logic [oau_pkg::NUM_ASM-1:0]   asm_mem_access,
  input  wire logic [oau_pkg::NUM_ASM-1:0]   asm_block_ok,
  input  wire logic [oau_pkg::NUM_ASM-1:0]   asm_block_spaced,
  input  wire logic [oau_pkg::NUM_ASM-1:0]   asm_xfer_done,
  output logic                               continue_out,
  output logic [oau_pkg::NUM_ASM-1:0]        asm_busy_out
);

  localparam int NA = oau_pkg::NUM_ASM;
  localparam int NU = oau_pkg::NUM_UNIT;
  localparam int CW = oau_pkg::CHAN_W;

  // Three-stage synchroniser step; a level counts once stages 2 and 3 agree
  function automatic logic [NU-1:0] settle(input logic [NU-1:0] s2,
                                            input logic [NU-1:0] s3,
                                            input logic [NU-1:0] old);
    settle = (s2 & s3) | (old & (s2 ^ s3));
  endfunction

  // Index of the lowest set bit of a mask
  function automatic logic [1:0] lowest(input logic [NA-1:0] m);
    lowest = 2'd0;
    for (int i = NA - 1; i >= 0; i--) begin
      if (m[i]) begin
        lowest = i[1:0];
      end
    end
  endfunction

  // Software registers and acceptance state
  logic [31:0]                   order_r;
  logic [oau_pkg::MADDR_W-1:0]   maddr_r;
  logic [1:0]                    view_sel_r;
  logic                          pending_r;
  logic                          accepted_r;
  logic                          rejected_r;
  logic [1:0]                    sel_r;
  logic [NA-1:0]                 hold_mask_r;
  logic [9:0]                    wait_r;
  oau_pkg::oau_class_t           class_r;
  oau_pkg::oau_state_t           state_r;

  // Synchronised unit status
  logic [NU-1:0] ub_s1, ub_s2, ub_s3, unit_busy_f;
  logic [NU-1:0] um_s1, um_s2, um_s3, unit_mech_f;

  // Assembler outputs and controls
  logic [NA-1:0]                 a_busy;
  logic [NA-1:0]                 a_run;
  logic [CW-1:0]                 a_chan  [NA];
  logic [oau_pkg::CMD_W-1:0]     a_cmd   [NA];
  logic [oau_pkg::MADDR_W-1:0]   a_maddr [NA];
  logic [oau_pkg::CNT_W-1:0]     a_proc  [NA];
  logic [oau_pkg::CNT_W-1:0]     a_space [NA];
  logic [NA-1:0]                 a_connect;
  logic [NA-1:0]                 a_release;
  logic [NA-1:0]                 a_load_all;
  logic [NA-1:0]                 a_load_chan;

  // Order fields
  logic [oau_pkg::OP_W-1:0]      f_op;
  logic [CW-1:0]                 f_unit;
  logic [oau_pkg::CNT_W-1:0]     f_proc;
  logic [oau_pkg::CNT_W-1:0]     f_space;
  logic [oau_pkg::CMD_W-1:0]     f_cmd;
  oau_pkg::oau_class_t           dec_class;

  // Selection results
  logic [NA-1:0]                 hold_mask;
  logic [NA-1:0]                 free_mask;
  logic [NA-1:0]                 match_free;
  logic [1:0]                    sel_c;
  logic                          dev_free;
  logic                          accept_c;
  logic [7:0]                    avail;

  // APB decode
  logic                          setup_ph;
  logic                          wr_go;
  logic                          mapped;
  logic [31:0]                   rd_c;

  assign f_op    = order_r[oau_pkg::OP_LSB +: oau_pkg::OP_W];
  assign f_unit  = order_r[oau_pkg::UNIT_LSB +: CW];
  assign f_proc  = order_r[oau_pkg::PROC_LSB +: oau_pkg::CNT_W];
  assign f_space = order_r[oau_pkg::SPACE_LSB +: oau_pkg::CNT_W];
  assign f_cmd   = order_r[oau_pkg::CMD_LSB +: oau_pkg::CMD_W];

  // Operation code classification
  oau_order_class u_class (
    .op_code     (f_op),
    .order_class (dec_class)
  );

  // Unit status pins cross into the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ub_s1       <= '0;
      ub_s2       <= '0;
      ub_s3       <= '0;
      unit_busy_f <= '0;
      um_s1       <= '0;
      um_s2       <= '0;
      um_s3       <= '0;
      unit_mech_f <= '0;
    end else begin
      ub_s1       <= unit_busy_pin;
      ub_s2       <= ub_s1;
      ub_s3       <= ub_s2;
      unit_busy_f <= settle(ub_s2, ub_s3, unit_busy_f);
      um_s1       <= unit_mech_ok_pin;
      um_s2       <= um_s1;
      um_s3       <= um_s2;
      unit_mech_f <= settle(um_s2, um_s3, unit_mech_f);
    end
  end

  // Assembler bank
  for (genvar g = 0; g < NA; g++) begin : g_asm
    oau_assembler u_asm (
      .pclk         (pclk),
      .presetn      (presetn),
      .connect      (a_connect[g]),
      .release_req  (a_release[g]),
      .load_all     (a_load_all[g]),
      .load_chan    (a_load_chan[g]),
      .chan_in      (f_unit),
      .cmd_in       (f_cmd),
      .maddr_in     (maddr_r),
      .proc_in      (f_proc),
      .space_in     (f_space),
      .xfer_active  (asm_xfer_active[g]),
      .mem_access   (asm_mem_access[g]),
      .block_ok     (asm_block_ok[g]),
      .block_spaced (asm_block_spaced[g]),
      .xfer_done    (asm_xfer_done[g]),
      .busy_r       (a_busy[g]),
      .run_r        (a_run[g]),
      .chan_r       (a_chan[g]),
      .cmd_r        (a_cmd[g]),
      .maddr_r      (a_maddr[g]),
      .proc_r       (a_proc[g]),
      .space_r      (a_space[g])
    );
  end

  // Compare stored channels with the named unit
  always_comb begin
    for (int i = 0; i < NA; i++) begin
      hold_mask[i] = (a_chan[i] == f_unit);
      free_mask[i] = !a_busy[i];
    end
    match_free = hold_mask & free_mask;
  end

  // Assembler choice and device check
  always_comb begin
    dev_free = !unit_busy_f[f_unit] && unit_mech_f[f_unit];
    sel_c    = 2'd0;
    accept_c = 1'b0;
    case (dec_class)
      oau_pkg::OC_A, oau_pkg::OC_UBC: begin
        sel_c    = (match_free != '0) ? lowest(match_free) : lowest(free_mask);
        accept_c = (free_mask != '0) && dev_free;
      end
      oau_pkg::OC_B: begin
        sel_c    = lowest(hold_mask);
        accept_c = (hold_mask != '0);
      end
      oau_pkg::OC_C: begin
        sel_c    = lowest(hold_mask);
        accept_c = (hold_mask != '0) && !a_run[lowest(hold_mask)]
                   && unit_mech_f[f_unit];
      end
      oau_pkg::OC_D: begin
        accept_c = VALID_UNITS[f_unit] && unit_mech_f[f_unit]
                   && !unit_busy_f[f_unit];
      end
      default: begin
        accept_c = 1'b0;
      end
    endcase
  end

  // Acceptance sequence: evaluate, signal continue, then load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= oau_pkg::ST_IDLE;
      sel_r       <= 2'd0;
      class_r     <= oau_pkg::OC_BAD;
      hold_mask_r <= '0;
      accepted_r  <= 1'b0;
      rejected_r  <= 1'b0;
      wait_r      <= '0;
    end else begin
      case (state_r)
        oau_pkg::ST_IDLE: begin
          wait_r <= '0;
          if (wr_go && (paddr == oau_pkg::OFS_ISSUE) && pwdata[0]) begin
            state_r    <= oau_pkg::ST_EVAL;
            accepted_r <= 1'b0;
            rejected_r <= 1'b0;
          end
        end
        oau_pkg::ST_EVAL: begin
          wait_r  <= wait_r + 1'b1;
          // Class of every evaluated order is reported, accepted or not
          class_r <= dec_class;
          if (accept_c && (wait_r < 10'(oau_pkg::CONT_LIMIT_CYC - 2))) begin
            state_r     <= oau_pkg::ST_CONT;
            sel_r       <= sel_c;
            hold_mask_r <= hold_mask;
          end else begin
            state_r    <= oau_pkg::ST_IDLE;
            rejected_r <= 1'b1;
          end
        end
        oau_pkg::ST_CONT: begin
          state_r <= oau_pkg::ST_LOAD;
        end
        oau_pkg::ST_LOAD: begin
          state_r    <= oau_pkg::ST_IDLE;
          accepted_r <= 1'b1;
        end
        default: begin
          state_r <= oau_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Continue pulse to the central computer, one cycle after acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      continue_out <= 1'b0;
    end else begin
      continue_out <= (state_r == oau_pkg::ST_EVAL) && accept_c
                      && (wait_r < 10'(oau_pkg::CONT_LIMIT_CYC - 2));
    end
  end

  // Assembler updates happen only in the cycle after continue
  always_comb begin
    a_connect   = '0;
    a_release   = '0;
    a_load_all  = '0;
    a_load_chan = '0;
    if (state_r == oau_pkg::ST_LOAD) begin
      case (class_r)
        oau_pkg::OC_A: begin
          a_connect[sel_r]   = 1'b1;
          a_load_all[sel_r]  = 1'b1;
          a_load_chan[sel_r] = 1'b1;
        end
        oau_pkg::OC_UBC: begin
          a_connect[sel_r]   = 1'b1;
          a_load_chan[sel_r] = 1'b1;
        end
        oau_pkg::OC_B: begin
          a_release = hold_mask_r;
        end
        oau_pkg::OC_C: begin
          a_connect[sel_r] = 1'b1;
        end
        default: begin
          a_connect = '0;
        end
      endcase
    end
  end

  // Busy/run pairs per assembler
  always_comb begin
    for (int i = 0; i < NA; i++) begin
      avail[2*i]   = a_busy[i];
      avail[2*i+1] = a_run[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asm_busy_out <= '0;
    end else begin
      asm_busy_out <= a_busy;
    end
  end

  // APB phases; order registers are frozen while an order is in flight
  assign setup_ph  = psel && !penable;
  assign wr_go     = psel && penable && pready && pwrite && !pslverr;
  assign pending_r = (state_r != oau_pkg::ST_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      order_r    <= oau_pkg::ORDER_RST;
      maddr_r    <= oau_pkg::MADDR_RST;
      view_sel_r <= 2'd0;
    end else if (wr_go) begin
      if ((paddr == oau_pkg::OFS_ORDER) && !pending_r) begin
        order_r <= pwdata;
      end
      if ((paddr == oau_pkg::OFS_MADDR) && !pending_r) begin
        maddr_r <= pwdata[oau_pkg::MADDR_W-1:0];
      end
      if (paddr == oau_pkg::OFS_VIEW_SEL) begin
        view_sel_r <= pwdata[1:0];
      end
    end
  end

  // Address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_c   = 32'h0000_0000;
    case (paddr)
      oau_pkg::OFS_ORDER:     rd_c = order_r;
      oau_pkg::OFS_MADDR:     rd_c = {17'h0_0000, maddr_r};
      oau_pkg::OFS_ISSUE:     rd_c = 32'h0000_0000;
      oau_pkg::OFS_STATUS:    rd_c = {24'h00_0000, class_r, sel_r,
                                      rejected_r, accepted_r, pending_r};
      oau_pkg::OFS_AVAIL:     rd_c = {24'h00_0000, avail};
      oau_pkg::OFS_VIEW_SEL:  rd_c = {30'h0000_0000, view_sel_r};
      oau_pkg::OFS_VIEW_PAR:  rd_c = {15'h0000, a_run[view_sel_r], a_busy[view_sel_r],
                                      a_space[view_sel_r], a_proc[view_sel_r],
                                      a_cmd[view_sel_r], a_chan[view_sel_r]};
      oau_pkg::OFS_VIEW_ADDR: rd_c = {17'h0_0000, a_maddr[view_sel_r]};
      default:                mapped = 1'b0;
    endcase
  end

  // Zero-wait answer: ready, data and error registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !mapped;
      prdata  <= (setup_ph && !pwrite) ? rd_c : 32'h0000_0000;
    end
  end

endmodule

// *** oau_accept_monitor.sv ***
`timescale 1ns/10ps
module oau_accept_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        continue_out,
  input wire logic [3:0]  asm_xfer_done,
  input wire logic [3:0]  asm_busy_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Order issue write and events that may move busy bits
  wire iss = psel && penable && pready && pwrite && paddr == oau_pkg::OFS_ISSUE && pwdata[0];
  wire ev  = continue_out || (|asm_xfer_done);
  // Setup cycle, then the answering access cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    ##1 psel && penable && pready;
  endsequence
  pready_setup_a: assert property (s_setup |-> s_access)
    else $error("no pready after setup");
  pready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  slverr_map_a: assert property (pready && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access not refused");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  cont_pulse_a: assert property (continue_out |=> !continue_out)
    else $error("continue longer than a cycle");
  cont_cause_a: assert property (
    continue_out |-> $past(iss) || $past(iss, 2) || $past(iss, 3))
    else $error("continue without issue");
  busy_rise_a: assert property (
    |(asm_busy_out & ~$past(asm_busy_out)) |->
    $past(continue_out) || $past(continue_out, 2) || $past(continue_out, 3))
    else $error("busy set without acceptance");
  busy_fall_a: assert property (
    |(~asm_busy_out & $past(asm_busy_out)) |-> $past(ev) || $past(ev, 2) || $past(ev, 3))
    else $error("busy cleared without cause");
endmodule
bind oau_accept oau_accept_monitor oau_accept_monitor_i (.*);

// *** oau_cpu_model.sv ***
`timescale 1ns/10ps
module oau_cpu_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        continue_out,
  output logic            took
);
  int unsigned wait_cnt;
  // Times each order from issue; a late continue counts as rejection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      took <= 1'b0;
      wait_cnt <= 0;
    end else if (psel && penable && pready && pwrite && paddr == oau_pkg::OFS_ISSUE) begin
      took <= 1'b0;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= wait_cnt + 1;
      if (continue_out && wait_cnt < oau_pkg::CONT_LIMIT_CYC) took <= 1'b1;
    end
  end
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        continue_out, took, slv;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic [15:0] unit_busy_pin, unit_mech_ok_pin;
  logic [3:0]  asm_xfer_active, asm_mem_access, asm_block_ok, asm_block_spaced;
  logic [3:0]  asm_xfer_done, asm_busy_out;
  int          error_cnt, checked;
  oau_accept oau_accept_i (.*);
  oau_cpu_model oau_cpu_model_i (.*);
  // Free running clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic final_report();
    $display("TB: checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail();
    error_cnt++;
    $display("MISMATCH %0t wait ran out", $time);
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail();
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask
  // Order with process 5, spacing 2, command 3, then wait for the verdict
  task automatic issue(input logic [4:0] op, input logic [3:0] u);
    int n;
    n = 0;
    apb(1'b1, oau_pkg::OFS_ORDER, {12'h000, 3'h3, 4'h2, 4'h5, u, op});
    apb(1'b1, oau_pkg::OFS_MADDR, 32'h0000_1230);
    apb(1'b1, oau_pkg::OFS_ISSUE, 32'h0000_0001);
    do begin
      apb(1'b0, oau_pkg::OFS_STATUS, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (rd[0] !== 1'b0) fail();
    st = rd;
    chk(took, st[1]);
  endtask
  task automatic view(input logic [1:0] a, input logic [31:0] ep, input logic [31:0] ea);
    apb(1'b1, oau_pkg::OFS_VIEW_SEL, {30'h0000_0000, a});
    apb(1'b0, oau_pkg::OFS_VIEW_PAR, 32'h0000_0000);
    chk(rd, ep);
    apb(1'b0, oau_pkg::OFS_VIEW_ADDR, 32'h0000_0000);
    chk(rd, ea);
  endtask
  task automatic avail(input logic [7:0] e);
    repeat (2) @(posedge pclk);
    apb(1'b0, oau_pkg::OFS_AVAIL, 32'h0000_0000);
    chk(rd, {24'h00_0000, e});
    chk(asm_busy_out, {e[6], e[4], e[2], e[0]});
  endtask
  // Pulses of {done, spaced, block ok, memory access}
  task automatic pulse(input logic [15:0] v);
    @(posedge pclk);
    {asm_xfer_done, asm_block_spaced, asm_block_ok, asm_mem_access} <= v;
    @(posedge pclk);
    {asm_xfer_done, asm_block_spaced, asm_block_ok, asm_mem_access} <= 16'h0000;
  endtask
  function automatic logic [2:0] cls(input logic [4:0] op);
    if (op <= oau_pkg::OP_A_LAST) return 3'h0;
    if (op <= oau_pkg::OP_B_LAST) return 3'h1;
    if (op <= oau_pkg::OP_C_LAST) return 3'h2;
    if (op <= oau_pkg::OP_D_LAST) return 3'h3;
    if (op <= oau_pkg::OP_UBC_LAST) return 3'h4;
    return 3'h5;
  endfunction
  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    unit_busy_pin = 16'h0000;
    unit_mech_ok_pin = 16'hFFFF;
    {asm_xfer_active, asm_mem_access, asm_block_ok, asm_block_spaced, asm_xfer_done} = 20'h0_0000;
    error_cnt = 0;
    checked = 0;
    rst();
    avail(8'h00);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(slv, 1'b1);
    for (int i = 0; i < 32; i++) begin
      issue(i[4:0], i[3:0]);
      chk(st[7:5], cls(i[4:0]));
    end
    rst();
    for (int i = 0; i < 4; i++) begin
      issue(i < 3 ? 5'h00 : 5'h1A, i[3:0] + 4'h2);
      chk(st[4:1], {i[1:0], 2'h1});
    end
    view(2'h3, 32'h0000_8005, 32'h0000_0000);
    view(2'h0, 32'h0000_92B2, 32'h0000_1230);
    issue(5'h01, 4'h6);
    chk(st[2:1], 2'h2);
    avail(8'h55);
    pulse(16'h0111);
    pulse(16'h0001);
    view(2'h0, 32'h0000_8A32, 32'h0000_1232);
    asm_xfer_active <= 4'h2;
    avail(8'h5D);
    issue(5'h10, 4'h3);
    chk(st[2:1], 2'h2);
    asm_xfer_active <= 4'h0;
    issue(5'h10, 4'h3);
    chk(st[4:1], 4'h5);
    pulse(16'h3000);
    avail(8'h50);
    view(2'h1, 32'h0000_12B3, 32'h0000_1230);
    issue(5'h02, 4'h3);
    chk(st[4:1], 4'h5);
    issue(5'h0C, 4'h4);
    chk(st[2:1], 2'h1);
    avail(8'h44);
    issue(5'h0D, 4'h9);
    chk(st[2:1], 2'h2);
    issue(5'h16, 4'h7);
    chk(st[2:1], 2'h1);
    avail(8'h44);
    unit_busy_pin <= 16'h0080;
    issue(5'h17, 4'h7);
    chk(st[2:1], 2'h2);
    issue(5'h00, 4'h7);
    chk(st[2:1], 2'h2);
    unit_mech_ok_pin <= 16'hFEFF;
    issue(5'h00, 4'h8);
    chk(st[2:1], 2'h2);
    final_report();
  end
endmodule
